// File: design/carrier_gen_pkg.sv
package carrier_gen_pkg;

    localparam int DATA_W       = 8;
    localparam int PRESCALE_W   = 12;
    localparam int ADDR_W       = 8;

    // register byte offsets
    localparam logic [7:0] OFS_SYMBOL_MODE   = 8'h00;
    localparam logic [7:0] OFS_CARRIER_MODE  = 8'h04;
    localparam logic [7:0] OFS_CARRIER_CTRL  = 8'h08;
    localparam logic [7:0] OFS_SYMBOL_CMP    = 8'h0c;
    localparam logic [7:0] OFS_CARRIER_LOW   = 8'h10;
    localparam logic [7:0] OFS_CARRIER_HIGH  = 8'h14;
    localparam logic [7:0] OFS_SYMBOL_COUNT  = 8'h18;
    localparam logic [7:0] OFS_CARRIER_COUNT = 8'h1c;
    localparam logic [7:0] OFS_IRQ_STATUS    = 8'h20;
    localparam logic [7:0] OFS_OUT_ENABLE    = 8'h24;

    // mode register fields
    localparam int MODE_CP_LSB    = 4;
    localparam int MODE_CP_MSB    = 6;
    localparam int MODE_START_BIT = 3;
    localparam int MODE_RUN_BIT   = 2;
    localparam int MODE_SEL_LSB   = 0;
    localparam int MODE_SEL_MSB   = 1;
    localparam logic [1:0] MODE_SEL_CG_CARRIER = 2'b11;
    localparam logic [1:0] MODE_SEL_CG_SYMBOL  = 2'b00;

    // carrier control register fields
    localparam int CTRL_GATE_BIT   = 7;
    localparam int CTRL_OUT_EN_BIT = 3;
    localparam int CTRL_STYLE_BIT  = 2;
    localparam int CTRL_NEXT_BIT   = 1;
    localparam int CTRL_ACTIVE_BIT = 0;
    localparam logic [7:0] CTRL_USED_MASK = 8'h8f;

    // status and output enable fields
    localparam int STAT_SYMBOL_BIT  = 0;
    localparam int STAT_CARRIER_BIT = 1;
    localparam int OUTEN_SYMBOL_BIT = 0;

    // count pulse selection codes
    localparam logic [2:0] CP_EDGE_RISE = 3'b000;
    localparam logic [2:0] CP_EDGE_FALL = 3'b001;
    localparam logic [2:0] CP_SEL_2     = 3'b010;
    localparam logic [2:0] CP_SEL_3     = 3'b011;
    localparam logic [2:0] CP_SEL_4     = 3'b100;
    localparam logic [2:0] CP_SEL_5     = 3'b101;
    localparam logic [2:0] CP_SEL_6     = 3'b110;
    localparam logic [2:0] CP_SEL_7     = 3'b111;

    // prescaler masks: tick when masked bits are all ones
    localparam logic [11:0] DIV_1    = 12'h000;
    localparam logic [11:0] DIV_2    = 12'h001;
    localparam logic [11:0] DIV_16   = 12'h00f;
    localparam logic [11:0] DIV_32   = 12'h01f;
    localparam logic [11:0] DIV_64   = 12'h03f;
    localparam logic [11:0] DIV_256  = 12'h0ff;
    localparam logic [11:0] DIV_1024 = 12'h3ff;
    localparam logic [11:0] DIV_4096 = 12'hfff;

    // reset values
    localparam logic [7:0]  RESET_MODE     = 8'h00;
    localparam logic [7:0]  RESET_CTRL     = 8'h00;
    localparam logic [7:0]  RESET_COMPARE  = 8'hff;
    localparam logic [7:0]  RESET_COUNT    = 8'h00;
    localparam logic [11:0] RESET_PRESCALE = 12'h000;

    typedef struct packed {
        logic       clear;
        logic       run;
        logic       cp;
        logic [7:0] compare;
    } chan_ctrl_t;

    typedef struct packed {
        logic [7:0] count;
        logic       match;
    } chan_state_t;

endpackage

// File: design/count_channel.sv
`timescale 1ns/10ps
`default_nettype none

module count_channel (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire carrier_gen_pkg::chan_ctrl_t  ctrl,
    output carrier_gen_pkg::chan_state_t      stat
);

    carrier_gen_pkg::chan_state_t state_reg;
    carrier_gen_pkg::chan_state_t state_next;

    always_comb begin
        state_next       = state_reg;
        state_next.match = 1'b0;
        if (ctrl.clear) begin
            state_next.count = carrier_gen_pkg::RESET_COUNT;
        end else if (ctrl.run && ctrl.cp) begin
            if (state_reg.count == ctrl.compare) begin
                state_next.count = carrier_gen_pkg::RESET_COUNT;
                state_next.match = 1'b1;
            end else begin
                state_next.count = state_reg.count + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign stat = state_reg;

endmodule

`default_nettype wire

// File: design/remote_carrier_generator.sv
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module remote_carrier_generator (
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        SYMBOL_EVENT_IN,
    input  wire logic        CARRIER_EVENT_IN,
    output logic             CARRIER_OUT_PIN,
    output logic             SYMBOL_OUT_PIN,
    output logic             SYMBOL_IRQ_FLAG,
    output logic             CARRIER_IRQ_FLAG
);

    typedef struct packed {
        logic [7:0]  symbol_mode;
        logic [7:0]  carrier_mode;
        logic [7:0]  ctrl;
        logic [7:0]  symbol_cmp;
        logic [7:0]  carrier_low;
        logic [7:0]  carrier_high;
        logic        symbol_irq;
        logic        carrier_irq;
        logic        symbol_out_en;
        logic        carrier_ff;
        logic        symbol_ff;
        logic        pin_data;
        logic        carrier_pin;
        logic [31:0] prdata;
        logic [11:0] prescale;
        logic [1:0]  sync1;
        logic [1:0]  sync2;
        logic [1:0]  sync3;
        logic [1:0]  filt;
    } state_t;

    state_t state_reg;
    state_t state_next;

    carrier_gen_pkg::chan_ctrl_t  sym_ctrl;
    carrier_gen_pkg::chan_ctrl_t  car_ctrl;
    carrier_gen_pkg::chan_state_t sym_stat;
    carrier_gen_pkg::chan_state_t car_stat;

    logic        wr_en;
    logic        rd_setup;
    logic        mapped;
    logic        cg_mode;
    logic        style;
    logic [1:0]  ev_rise;
    logic [1:0]  ev_fall;
    logic [31:0] rd_mux;

    function automatic logic tick(input logic [11:0] pre,
                                  input logic [11:0] mask);
        tick = ((pre & mask) == mask);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    always_comb begin
        wr_en    = PSEL && PENABLE && PWRITE;
        rd_setup = PSEL && !PENABLE && !PWRITE;
        mapped   = (PADDR[1:0] == 2'b00) &&
                   (PADDR <= carrier_gen_pkg::OFS_OUT_ENABLE);
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (PADDR)
            carrier_gen_pkg::OFS_SYMBOL_MODE:
                rd_mux[7:0] = state_reg.symbol_mode;
            carrier_gen_pkg::OFS_CARRIER_MODE:
                rd_mux[7:0] = state_reg.carrier_mode;
            carrier_gen_pkg::OFS_CARRIER_CTRL:
                rd_mux[7:0] = state_reg.ctrl;
            carrier_gen_pkg::OFS_SYMBOL_CMP:
                rd_mux[7:0] = state_reg.symbol_cmp;
            carrier_gen_pkg::OFS_CARRIER_LOW:
                rd_mux[7:0] = state_reg.carrier_low;
            carrier_gen_pkg::OFS_CARRIER_HIGH:
                rd_mux[7:0] = state_reg.carrier_high;
            carrier_gen_pkg::OFS_SYMBOL_COUNT:
                rd_mux[7:0] = sym_stat.count;
            carrier_gen_pkg::OFS_CARRIER_COUNT:
                rd_mux[7:0] = car_stat.count;
            carrier_gen_pkg::OFS_IRQ_STATUS: begin
                rd_mux[carrier_gen_pkg::STAT_SYMBOL_BIT]  =
                    state_reg.symbol_irq;
                rd_mux[carrier_gen_pkg::STAT_CARRIER_BIT] =
                    state_reg.carrier_irq;
            end
            carrier_gen_pkg::OFS_OUT_ENABLE:
                rd_mux[carrier_gen_pkg::OUTEN_SYMBOL_BIT] =
                    state_reg.symbol_out_en;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // event pin edges after three-stage synchroniser

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            ev_rise[i] = (state_reg.sync2[i] == state_reg.sync3[i]) &&
                         state_reg.sync3[i] && !state_reg.filt[i];
            ev_fall[i] = (state_reg.sync2[i] == state_reg.sync3[i]) &&
                         !state_reg.sync3[i] && state_reg.filt[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel control

    always_comb begin
        cg_mode = (state_reg.carrier_mode[carrier_gen_pkg::MODE_SEL_MSB:
                       carrier_gen_pkg::MODE_SEL_LSB] ==
                   carrier_gen_pkg::MODE_SEL_CG_CARRIER) &&
                  (state_reg.symbol_mode[carrier_gen_pkg::MODE_SEL_MSB:
                       carrier_gen_pkg::MODE_SEL_LSB] ==
                   carrier_gen_pkg::MODE_SEL_CG_SYMBOL);
        style   = state_reg.ctrl[carrier_gen_pkg::CTRL_STYLE_BIT];
        sym_ctrl.clear = wr_en &&
            (PADDR == carrier_gen_pkg::OFS_SYMBOL_MODE) &&
            PWDATA[carrier_gen_pkg::MODE_START_BIT];
        sym_ctrl.run = state_reg.symbol_mode[carrier_gen_pkg::MODE_RUN_BIT];
        sym_ctrl.compare = state_reg.symbol_cmp;
        case (state_reg.symbol_mode[carrier_gen_pkg::MODE_CP_MSB:
                  carrier_gen_pkg::MODE_CP_LSB])
            carrier_gen_pkg::CP_EDGE_RISE: sym_ctrl.cp = ev_rise[0];
            carrier_gen_pkg::CP_EDGE_FALL: sym_ctrl.cp = ev_fall[0];
            carrier_gen_pkg::CP_SEL_2:     sym_ctrl.cp = car_stat.match;
            carrier_gen_pkg::CP_SEL_3:     sym_ctrl.cp =
                tick(state_reg.prescale, carrier_gen_pkg::DIV_32);
            carrier_gen_pkg::CP_SEL_4:     sym_ctrl.cp =
                tick(state_reg.prescale, carrier_gen_pkg::DIV_4096);
            carrier_gen_pkg::CP_SEL_5:     sym_ctrl.cp =
                tick(state_reg.prescale, carrier_gen_pkg::DIV_1024);
            carrier_gen_pkg::CP_SEL_6:     sym_ctrl.cp =
                tick(state_reg.prescale, carrier_gen_pkg::DIV_256);
            carrier_gen_pkg::CP_SEL_7:     sym_ctrl.cp =
                tick(state_reg.prescale, carrier_gen_pkg::DIV_64);
            default:                       sym_ctrl.cp = 1'b0;
        endcase
        car_ctrl.clear = wr_en &&
            (PADDR == carrier_gen_pkg::OFS_CARRIER_MODE) &&
            PWDATA[carrier_gen_pkg::MODE_START_BIT];
        car_ctrl.run = cg_mode &&
            state_reg.carrier_mode[carrier_gen_pkg::MODE_RUN_BIT];
        car_ctrl.compare = state_reg.carrier_ff ?
            state_reg.carrier_high : state_reg.carrier_low;
        case (state_reg.carrier_mode[carrier_gen_pkg::MODE_CP_MSB:
                  carrier_gen_pkg::MODE_CP_LSB])
            carrier_gen_pkg::CP_EDGE_RISE: car_ctrl.cp = ev_rise[1];
            carrier_gen_pkg::CP_EDGE_FALL: car_ctrl.cp = ev_fall[1];
            carrier_gen_pkg::CP_SEL_2:     car_ctrl.cp =
                tick(state_reg.prescale, carrier_gen_pkg::DIV_2);
            carrier_gen_pkg::CP_SEL_3:     car_ctrl.cp =
                tick(state_reg.prescale, carrier_gen_pkg::DIV_1);
            carrier_gen_pkg::CP_SEL_4:     car_ctrl.cp =
                tick(state_reg.prescale, carrier_gen_pkg::DIV_1024);
            carrier_gen_pkg::CP_SEL_5:     car_ctrl.cp =
                tick(state_reg.prescale, carrier_gen_pkg::DIV_256);
            carrier_gen_pkg::CP_SEL_6:     car_ctrl.cp =
                tick(state_reg.prescale, carrier_gen_pkg::DIV_64);
            carrier_gen_pkg::CP_SEL_7:     car_ctrl.cp =
                tick(state_reg.prescale, carrier_gen_pkg::DIV_16);
            default:                       car_ctrl.cp = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_next          = state_reg;
        state_next.prescale = state_reg.prescale + 12'h001;
        state_next.sync1    = {CARRIER_EVENT_IN, SYMBOL_EVENT_IN};
        state_next.sync2    = state_reg.sync1;
        state_next.sync3    = state_reg.sync2;
        for (int i = 0; i < 2; i++) begin
            if (state_reg.sync2[i] == state_reg.sync3[i]) begin
                state_next.filt[i] = state_reg.sync3[i];
            end
        end

        // software writes; hardware sets below override clears
        if (wr_en) begin
            case (PADDR)
                carrier_gen_pkg::OFS_SYMBOL_MODE: begin
                    state_next.symbol_mode = PWDATA[7:0];
                    state_next.symbol_mode[carrier_gen_pkg::MODE_START_BIT] =
                        1'b0;
                    if (PWDATA[carrier_gen_pkg::MODE_START_BIT]) begin
                        state_next.symbol_irq = 1'b0;
                    end
                end
                carrier_gen_pkg::OFS_CARRIER_MODE: begin
                    state_next.carrier_mode = PWDATA[7:0];
                    state_next.carrier_mode[carrier_gen_pkg::MODE_START_BIT] =
                        1'b0;
                    if (PWDATA[carrier_gen_pkg::MODE_START_BIT]) begin
                        state_next.carrier_irq = 1'b0;
                        state_next.carrier_ff  = 1'b0;
                    end
                end
                carrier_gen_pkg::OFS_CARRIER_CTRL:
                    state_next.ctrl = PWDATA[7:0] &
                        carrier_gen_pkg::CTRL_USED_MASK;
                carrier_gen_pkg::OFS_SYMBOL_CMP:
                    state_next.symbol_cmp = PWDATA[7:0];
                carrier_gen_pkg::OFS_CARRIER_LOW:
                    state_next.carrier_low = PWDATA[7:0];
                carrier_gen_pkg::OFS_CARRIER_HIGH:
                    state_next.carrier_high = PWDATA[7:0];
                carrier_gen_pkg::OFS_IRQ_STATUS: begin
                    if (PWDATA[carrier_gen_pkg::STAT_SYMBOL_BIT]) begin
                        state_next.symbol_irq = 1'b0;
                    end
                    if (PWDATA[carrier_gen_pkg::STAT_CARRIER_BIT]) begin
                        state_next.carrier_irq = 1'b0;
                    end
                end
                carrier_gen_pkg::OFS_OUT_ENABLE:
                    state_next.symbol_out_en =
                        PWDATA[carrier_gen_pkg::OUTEN_SYMBOL_BIT];
                default: state_next.prdata = state_reg.prdata;
            endcase
        end

        // carrier phase matches
        if (car_stat.match) begin
            state_next.carrier_ff = !state_reg.carrier_ff;
            if (!state_reg.carrier_ff) begin
                state_next.carrier_irq = 1'b1;
            end
        end

        // symbol interval match
        if (sym_stat.match) begin
            state_next.symbol_irq = 1'b1;
            state_next.symbol_ff  = !state_reg.symbol_ff;
            if (cg_mode) begin
                state_next.ctrl[carrier_gen_pkg::CTRL_ACTIVE_BIT] =
                    state_reg.ctrl[carrier_gen_pkg::CTRL_NEXT_BIT];
            end
        end

        // pin data only changes while the pin is low, at a carrier match, or while the style bit is set
        if (!state_reg.carrier_pin || car_stat.match || style) begin
            state_next.pin_data =
                state_reg.ctrl[carrier_gen_pkg::CTRL_ACTIVE_BIT];
        end
        state_next.carrier_pin =
            state_reg.ctrl[carrier_gen_pkg::CTRL_OUT_EN_BIT] &&
            cg_mode && state_reg.pin_data &&
            (style || state_reg.carrier_ff);

        if (rd_setup) begin
            state_next.prdata = rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and channels

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_reg              <= '0;
            state_reg.symbol_mode  <= carrier_gen_pkg::RESET_MODE;
            state_reg.carrier_mode <= carrier_gen_pkg::RESET_MODE;
            state_reg.ctrl         <= carrier_gen_pkg::RESET_CTRL;
            state_reg.symbol_cmp   <= carrier_gen_pkg::RESET_COMPARE;
            state_reg.carrier_low  <= carrier_gen_pkg::RESET_COMPARE;
            state_reg.carrier_high <= carrier_gen_pkg::RESET_COMPARE;
            state_reg.prescale     <= carrier_gen_pkg::RESET_PRESCALE;
        end else begin
            state_reg <= state_next;
        end
    end

    count_channel symbol_chan (
        .clk  (CLK_SYS),
        .rst  (RST),
        .ctrl (sym_ctrl),
        .stat (sym_stat)
    );

    count_channel carrier_chan (
        .clk  (CLK_SYS),
        .rst  (RST),
        .ctrl (car_ctrl),
        .stat (car_stat)
    );

    assign PRDATA           = state_reg.prdata;
    assign PREADY           = 1'b1;
    assign PSLVERR          = PSEL && PENABLE && !mapped;
    assign CARRIER_OUT_PIN  = state_reg.carrier_pin;
    assign SYMBOL_OUT_PIN   = state_reg.symbol_out_en && state_reg.symbol_ff;
    assign SYMBOL_IRQ_FLAG  = state_reg.symbol_irq;
    assign CARRIER_IRQ_FLAG = state_reg.carrier_irq;

endmodule

`default_nettype wire

// File: testbench/ir_led_model.sv
`timescale 1ns/10ps
`default_nettype none

// infrared emitter model: measures the lengths of lit and dark runs
module ir_led_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic led_in
);
    int   run_len, high_width, low_width, falls;
    logic last;

    always @(posedge clk) begin
        if (rst) begin
            {run_len, high_width, low_width, falls} <= '0;
            last       <= 1'b0;
        end else begin
            last <= led_in;
            if (led_in !== last) begin
                run_len <= 1;
                if (last === 1'b1) begin
                    high_width <= run_len;
                    falls      <= falls + 1;
                end else begin
                    low_width <= run_len;
                end
            end else begin
                run_len <= run_len + 1;
            end
        end
    end
endmodule

`default_nettype wire

// File: testbench/carrier_gen_properties.sv
`timescale 1ns/10ps
`default_nettype none

module carrier_gen_properties (
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        CARRIER_OUT_PIN,
    input wire logic        SYMBOL_IRQ_FLAG,
    input wire logic        CARRIER_IRQ_FLAG
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    wire logic wr_acc  = PSEL && PENABLE && PWRITE;
    wire logic sym_clr = wr_acc && ((PADDR == 8'h20 && PWDATA[0])
                         || (PADDR == 8'h00 && PWDATA[3]));
    wire logic car_clr = wr_acc && ((PADDR == 8'h20 && PWDATA[1])
                         || (PADDR == 8'h04 && PWDATA[3]));

    sequence s_setup_rd(a);
        PSEL && !PENABLE && !PWRITE && PADDR == a;
    endsequence
    sequence s_access;
        PSEL && PENABLE;
    endsequence
    sequence s_ctrl_off;
        wr_acc && PADDR == carrier_gen_pkg::OFS_CARRIER_CTRL && !PWDATA[3];
    endsequence

    a_ready_always: assert property (PREADY)
        else $error("ready dropped");
    a_unmapped_err: assert property (PSEL && PENABLE && PADDR > 8'h24
        |-> PSLVERR) else $error("no error on unmapped access");
    a_err_idle: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
        else $error("error outside access");
    a_unmapped_zero: assert property (PSEL && PENABLE && !PWRITE
        && PADDR > 8'h24 |-> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_narrow: assert property (PRDATA[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_reset_quiet: assert property (disable iff (1'b0) RST |=>
        !CARRIER_OUT_PIN && !SYMBOL_IRQ_FLAG && !CARRIER_IRQ_FLAG)
        else $error("outputs active after reset");
    a_sym_sticky: assert property (
        SYMBOL_IRQ_FLAG && !sym_clr |=> SYMBOL_IRQ_FLAG)
        else $error("symbol flag lost");
    a_car_sticky: assert property (
        CARRIER_IRQ_FLAG && !car_clr |=> CARRIER_IRQ_FLAG)
        else $error("carrier flag lost");
    a_status_read: assert property (
        s_setup_rd(carrier_gen_pkg::OFS_IRQ_STATUS) ##1 s_access |->
        PRDATA[1:0] == {$past(CARRIER_IRQ_FLAG), $past(SYMBOL_IRQ_FLAG)})
        else $error("status read differs from flags");
    a_outen_off: assert property (
        s_ctrl_off ##1 !wr_acc |=> !CARRIER_OUT_PIN)
        else $error("pin driven with output disabled");
endmodule

bind remote_carrier_generator carrier_gen_properties
    carrier_gen_properties_inst (.*);

`default_nettype wire

// File: testbench/tb_remote_carrier_generator.sv
`timescale 1ns/10ps
`default_nettype none

module tb_remote_carrier_generator;
    localparam int DIVS [8] = '{0, 0, 2, 1, 1024, 256, 64, 16};
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic        sym_ev, car_ev, car_pin, sym_pin, sym_flag, car_flag;
    logic        err, s1;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seed, rd, keep;
    int          n_mismatch, comparisons, cyc, t1, h, l, f0, hc;

    remote_carrier_generator remote_carrier_generator_inst (
        .CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SYMBOL_EVENT_IN(sym_ev),
        .CARRIER_EVENT_IN(car_ev), .CARRIER_OUT_PIN(car_pin),
        .SYMBOL_OUT_PIN(sym_pin), .SYMBOL_IRQ_FLAG(sym_flag),
        .CARRIER_IRQ_FLAG(car_flag)
    );
    ir_led_model ir_led_model_inst (.clk(clk_sys), .rst(rst),
                                    .led_in(car_pin));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc    <= cyc + 1;
        car_ev <= seed[0];
        sym_ev <= seed[1];
    end

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] reset_val(input int a);
        return (a >= 8'h0c && a <= 8'h14) ? 32'h0000_00ff : 32'h0;
    endfunction

    task automatic wrap_up();
        $display("counts: comparisons %0d mismatches %0d", comparisons,
                 n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic timeout(input string what);
        n_mismatch++;
        $display("MISMATCH %s expected event seen none", what);
        wrap_up();
    endtask

    task automatic chk_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_cnt(input string what, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd  = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 50) timeout("pready");
        @(posedge clk_sys);
    endtask

    task automatic wait_falls(input int k, input int bound);
        int n = 0;
        f0 = ir_led_model_inst.falls;
        while (ir_led_model_inst.falls < f0 + k && n < bound) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= bound) timeout("carrier edges");
    endtask

    task automatic wait_sym();
        int n = 0;
        while (sym_flag !== 1'b1 && n < 5000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 5000) timeout("symbol flag");
    endtask

    task automatic count_high(input int len);
        hc = 0;
        repeat (len) begin
            @(posedge clk_sys);
            if (car_pin === 1'b1) hc++;
        end
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h0000_dfd6;
        {cyc, n_mismatch, comparisons} = '0;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, sym_ev, car_ev} = '0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk_val("pins after reset", 32'h0,
                32'({car_pin, sym_pin, sym_flag, car_flag}));
        for (int a = 0; a <= 8'h28; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk_val("reset read", (a == 8'h28) ? 32'h0 : reset_val(a), rd);
            chk_val("slave error", 32'(a == 8'h28), 32'(err));
        end
        apb(1'b1, 8'h28, rnd());
        chk_val("unmapped write", 32'h1, 32'(err));
        for (int a = 8'h08; a <= 8'h14; a += 4) begin
            keep = (rnd() & 32'hff) | 32'h1;
            apb(1'b1, 8'(a), keep);
            apb(1'b0, 8'(a), 32'h0);
            chk_val("readback", keep & ((a == 8'h08) ? 32'h8f : 32'hff), rd);
        end
        $display("test registers done");
        for (int c = 2; c < 8; c++) begin
            h = 1 + int'(rnd() % 3);
            l = 1 + int'(rnd() % 3);
            apb(1'b1, carrier_gen_pkg::OFS_CARRIER_HIGH, 32'(h));
            apb(1'b1, carrier_gen_pkg::OFS_CARRIER_LOW, 32'(l));
            apb(1'b1, carrier_gen_pkg::OFS_CARRIER_CTRL, 32'h09);
            apb(1'b1, carrier_gen_pkg::OFS_CARRIER_MODE,
                {25'h0, 3'(c), 4'hf});
            wait_falls(3, 40 * (h + l + 2) * DIVS[c]);
            chk_cnt("high width", (h + 1) * DIVS[c],
                    ir_led_model_inst.high_width);
            chk_cnt("low width", (l + 1) * DIVS[c],
                    ir_led_model_inst.low_width);
            chk_val("carrier flag", 32'h1, 32'(car_flag));
            $display("test carrier code %0d done", c);
        end
        apb(1'b1, carrier_gen_pkg::OFS_CARRIER_MODE, 32'h3f);
        apb(1'b1, carrier_gen_pkg::OFS_CARRIER_CTRL, 32'h0d);
        repeat (4) @(posedge clk_sys);
        count_high(16);
        chk_cnt("steady high", 16, hc);
        apb(1'b1, carrier_gen_pkg::OFS_CARRIER_CTRL, 32'h08);
        repeat (12) @(posedge clk_sys);
        count_high(16);
        chk_cnt("data zero", 0, hc);
        apb(1'b1, carrier_gen_pkg::OFS_CARRIER_CTRL, 32'h0a);
        apb(1'b1, carrier_gen_pkg::OFS_CARRIER_CTRL, 32'h00);
        apb(1'b0, carrier_gen_pkg::OFS_CARRIER_CTRL, 32'h0);
        chk_val("next bit cleared", 32'h0, rd);
        $display("test output style done");
        apb(1'b1, carrier_gen_pkg::OFS_CARRIER_CTRL, 32'h09);
        apb(1'b1, carrier_gen_pkg::OFS_SYMBOL_MODE, 32'h01);
        apb(1'b0, carrier_gen_pkg::OFS_CARRIER_COUNT, 32'h0);
        keep = rd;
        apb(1'b0, carrier_gen_pkg::OFS_CARRIER_COUNT, 32'h0);
        chk_val("count outside mode", keep, rd);
        count_high(16);
        chk_cnt("pin outside mode", 0, hc);
        apb(1'b1, carrier_gen_pkg::OFS_SYMBOL_MODE, 32'h00);
        wait_falls(2, 200);
        $display("test mode select done");
        apb(1'b1, carrier_gen_pkg::OFS_OUT_ENABLE, 32'h1);
        apb(1'b1, carrier_gen_pkg::OFS_SYMBOL_CMP, 32'h3);
        apb(1'b1, carrier_gen_pkg::OFS_CARRIER_CTRL, 32'h0a);
        apb(1'b1, carrier_gen_pkg::OFS_SYMBOL_MODE, 32'h3c);
        wait_sym();
        t1 = cyc;
        apb(1'b0, carrier_gen_pkg::OFS_IRQ_STATUS, 32'h0);
        chk_val("status symbol bit", 32'h1, rd & 32'h1);
        apb(1'b1, carrier_gen_pkg::OFS_IRQ_STATUS, 32'h1);
        s1 = sym_pin;
        apb(1'b0, carrier_gen_pkg::OFS_CARRIER_CTRL, 32'h0);
        chk_val("active bit", 32'h1, rd & 32'h1);
        wait_sym();
        chk_cnt("symbol interval", 4 * 32, cyc - t1);
        repeat (2) @(posedge clk_sys);
        chk_val("symbol pin", 32'(!s1), 32'(sym_pin));
        wait_falls(2, 200);
        $display("test symbol reload done");
        wrap_up();
    end
endmodule

`default_nettype wire
